// ---- design/daslm_pkg.sv ----
`default_nettype none
// ****************************************
// Downstream slot receive mask constants
// ****************************************
package daslm_pkg;
  localparam int          DASLM_SLOTS        = 32;
  localparam int          DASLM_HI_BASE      = 24;
  localparam int          DASLM_HI_W         = 8;
  localparam int          DASLM_LO_W         = 24;
  localparam int          DASLM_SKIP_W       = 5;
  localparam int          DASLM_COUNT_W      = 8;
  localparam int          DASLM_SLOT_NUM_W   = 5;
  localparam logic [7:0]  DASLM_MASK_HI_ADDR = 8'h68;
  localparam logic [7:0]  DASLM_SKIP_ADDR    = 8'h69;
  localparam logic [7:0]  DASLM_MASK_HI_RST  = 8'h00;
  localparam logic [4:0]  DASLM_SKIP_RST     = 5'h00;
  localparam logic [7:0]  DASLM_UNMAPPED_RD  = 8'h00;
  localparam logic [31:0] DASLM_SEL_RST      = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- design/daslm_shadow.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Pending to active shadow register
// ****************************************
module daslm_shadow #(
  parameter int             WIDTH = 8,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             commit,
  input  wire logic [WIDTH-1:0] pending,
  output logic      [WIDTH-1:0] active
);
  logic [WIDTH-1:0] active_r;
  logic [WIDTH-1:0] active_nxt;

  initial begin
    if (WIDTH < 1) $error("daslm_shadow: WIDTH must be positive");
  end

  // Load only on commit
  always_comb begin
    active_nxt = active_r;
    if (commit) begin
      active_nxt = pending;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      active_r <= RST;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign active = active_r;
endmodule // daslm_shadow
`default_nettype wire

// ---- design/daslm_top.sv ----
`timescale 1ns/100ps
`default_nettype none
//
// Behaviour
// - Register chooses which downstream slots 24 to 31 this target node receives.
// - Selected downstream slots are forwarded toward the local serial audio port.
// - With every mask bit clear, the legacy slot count picks the taken slots.
// - Mask writes stay pending until the controller commits a new bus structure.
// - Bit n governs slot 24 plus n; bit 0 slot 24, bit 7 slot 31.
// - A bit of 0 disables its slot, a bit of 1 enables it.
// - Target-only register; every bit readable and writable by software.
// - Channel skip applies only with some mask bit set and nonzero slot count.
module daslm_top #(
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              commit_bus_structure,
  input  wire logic [23:0]       down_rx_select_lo,
  input  wire logic [7:0]        local_down_slot_count,
  input  wire logic              slot_strobe,
  input  wire logic [4:0]        slot_num,
  input  wire logic [DATA_W-1:0] slot_data,
  output logic      [31:0]       down_rx_select,
  output logic                   legacy_count_mode,
  output logic      [4:0]        down_channel_skip_used,
  output logic                   port_valid,
  output logic      [4:0]        port_slot,
  output logic      [DATA_W-1:0] port_data
);
  initial begin
    if (DATA_W < 1) $error("daslm_top: DATA_W must be positive");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] legacy_vec(input logic [7:0] cnt);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < daslm_pkg::DASLM_SLOTS; i++) begin
      if (8'(i) < cnt) v[i] = 1'b1;
    end
    return v;
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] down_rx_select_hi_r;
  logic [7:0] down_rx_select_hi_nxt;
  logic [4:0] down_channel_skip_r;
  logic [4:0] down_channel_skip_nxt;
  logic [7:0] reg_rdata_r;
  logic [7:0] reg_rdata_nxt;

  always_comb begin
    down_rx_select_hi_nxt = down_rx_select_hi_r;
    down_channel_skip_nxt = down_channel_skip_r;
    reg_rdata_nxt         = reg_rdata_r;
    if (reg_wr && reg_addr == daslm_pkg::DASLM_MASK_HI_ADDR) begin
      down_rx_select_hi_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == daslm_pkg::DASLM_SKIP_ADDR) begin
      down_channel_skip_nxt = reg_wdata[daslm_pkg::DASLM_SKIP_W-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        daslm_pkg::DASLM_MASK_HI_ADDR: reg_rdata_nxt = down_rx_select_hi_r;
        daslm_pkg::DASLM_SKIP_ADDR:    reg_rdata_nxt = {3'h0, down_channel_skip_r};
        default:                       reg_rdata_nxt = daslm_pkg::DASLM_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      down_rx_select_hi_r <= daslm_pkg::DASLM_MASK_HI_RST;
      down_channel_skip_r <= daslm_pkg::DASLM_SKIP_RST;
      reg_rdata_r         <= daslm_pkg::DASLM_UNMAPPED_RD;
    end else begin
      down_rx_select_hi_r <= down_rx_select_hi_nxt;
      down_channel_skip_r <= down_channel_skip_nxt;
      reg_rdata_r         <= reg_rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // ****************************************
  // Committed mask
  // ****************************************
  logic [7:0] hi_active;

  daslm_shadow #(
    .WIDTH (daslm_pkg::DASLM_HI_W),
    .RST   (daslm_pkg::DASLM_MASK_HI_RST)
  ) u_hi_shadow (
    .clock   (clock),
    .nrst    (nrst),
    .commit  (commit_bus_structure),
    .pending (down_rx_select_hi_r),
    .active  (hi_active)
  );

  // ****************************************
  // Selection vector
  // ****************************************
  logic [31:0] full_mask;
  logic        any_mask;
  logic [31:0] select_r;
  logic [31:0] select_nxt;
  logic        legacy_r;
  logic        legacy_nxt;
  logic [4:0]  skip_used_r;
  logic [4:0]  skip_used_nxt;

  // Slot 24 plus n sits at bit 24 plus n
  assign full_mask = {hi_active, down_rx_select_lo};
  assign any_mask  = |full_mask;

  always_comb begin
    legacy_nxt    = !any_mask;
    skip_used_nxt = 5'h00;
    if (any_mask) begin
      select_nxt = full_mask;
    end else begin
      select_nxt = legacy_vec(local_down_slot_count);
    end
    if (any_mask && local_down_slot_count != 8'h00) begin
      skip_used_nxt = down_channel_skip_r;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      select_r    <= daslm_pkg::DASLM_SEL_RST;
      legacy_r    <= 1'b1;
      skip_used_r <= daslm_pkg::DASLM_SKIP_RST;
    end else begin
      select_r    <= select_nxt;
      legacy_r    <= legacy_nxt;
      skip_used_r <= skip_used_nxt;
    end
  end

  assign down_rx_select         = select_r;
  assign legacy_count_mode      = legacy_r;
  assign down_channel_skip_used = skip_used_r;

  // ****************************************
  // Slot extraction
  // ****************************************
  logic              pv_r;
  logic              pv_nxt;
  logic [4:0]        ps_r;
  logic [4:0]        ps_nxt;
  logic [DATA_W-1:0] pd_r;
  logic [DATA_W-1:0] pd_nxt;

  always_comb begin
    pv_nxt = slot_strobe && select_r[slot_num];
    ps_nxt = ps_r;
    pd_nxt = pd_r;
    if (pv_nxt) begin
      ps_nxt = slot_num;
      pd_nxt = slot_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pv_r <= 1'b0;
      ps_r <= 5'h00;
      pd_r <= '0;
    end else begin
      pv_r <= pv_nxt;
      ps_r <= ps_nxt;
      pd_r <= pd_nxt;
    end
  end

  assign port_valid = pv_r;
  assign port_slot  = ps_r;
  assign port_data  = pd_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence hi_write_s;
    reg_wr && reg_addr == daslm_pkg::DASLM_MASK_HI_ADDR;
  endsequence

  sequence slot_taken_s;
    slot_strobe && select_r[slot_num];
  endsequence

  mask_write_a: assert property (@(posedge clock) disable iff (!nrst)
    hi_write_s |=> down_rx_select_hi_r == $past(reg_wdata))
    else $error("mask write not stored");

  mask_read_a: assert property (@(posedge clock) disable iff (!nrst)
    reg_rd && reg_addr == daslm_pkg::DASLM_MASK_HI_ADDR
    |=> reg_rdata == $past(down_rx_select_hi_r))
    else $error("mask read wrong");

  commit_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    hi_write_s ##0 !commit_bus_structure ##1 !commit_bus_structure[*2]
    |-> $stable(hi_active))
    else $error("mask took effect without commit");

  commit_load_a: assert property (@(posedge clock) disable iff (!nrst)
    commit_bus_structure |=> hi_active == $past(down_rx_select_hi_r))
    else $error("commit did not load mask");

  hi_map_a: assert property (@(posedge clock) disable iff (!nrst)
    any_mask |=> down_rx_select[31:24] == $past(hi_active) && !legacy_count_mode)
    else $error("upper slots mismapped");

  legacy_sel_a: assert property (@(posedge clock) disable iff (!nrst)
    !any_mask |=> legacy_count_mode
      && down_rx_select == legacy_vec($past(local_down_slot_count)))
    else $error("legacy count not applied");

  skip_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    (!any_mask || local_down_slot_count == 8'h00) |=> down_channel_skip_used == 5'h00)
    else $error("skip applied while gated off");

  slot_fwd_a: assert property (@(posedge clock) disable iff (!nrst)
    slot_taken_s |=> port_valid && port_slot == $past(slot_num)
      && port_data == $past(slot_data))
    else $error("selected slot not forwarded");

  slot_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    !(slot_strobe && select_r[slot_num]) |=> !port_valid)
    else $error("unselected slot forwarded");
endmodule // daslm_top
`default_nettype wire

// ---- sim/daslm_slot_source.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Upstream downstream-slot source
// ****************************************
module daslm_slot_source #(
  parameter int DATA_W = 32
) (
  input  wire logic              clock,
  input  wire logic              go,
  output logic                   slot_strobe,
  output logic      [4:0]        slot_num,
  output logic      [DATA_W-1:0] slot_data
);
  initial begin
    slot_strobe = 1'b0;
    slot_num    = 5'h00;
    slot_data   = '0;
    forever begin
      @(posedge clock);
      if (go) begin
        for (int n = 0; n < 32; n++) begin
          slot_strobe <= 1'b1;
          slot_num    <= 5'(n);
          slot_data   <= DATA_W'(32'hda00_0000 + n);
          @(posedge clock);
        end
        // Released lines show the inverse of the last value
        slot_strobe <= 1'b0;
        slot_num    <= ~slot_num;
        slot_data   <= ~slot_data;
      end
    end
  end
endmodule // daslm_slot_source
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clock, nrst, reg_wr, reg_rd, commit, slot_strobe, go, legacy, port_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, count;
  logic [23:0] lo;
  logic [4:0]  slot_num, skip_used, port_slot;
  logic [31:0] slot_data, sel, port_data;
  int          error_cnt, n_checks, fwd, cyc;
  // ****************************************
  // Clock, reset, model and design
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  daslm_slot_source #(.DATA_W(32)) src (.clock(clock), .go(go), .slot_strobe(slot_strobe),
    .slot_num(slot_num), .slot_data(slot_data));
  daslm_top #(.DATA_W(32)) dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .commit_bus_structure(commit), .down_rx_select_lo(lo), .local_down_slot_count(count),
    .slot_strobe(slot_strobe), .slot_num(slot_num), .slot_data(slot_data),
    .down_rx_select(sel), .legacy_count_mode(legacy), .down_channel_skip_used(skip_used),
    .port_valid(port_valid), .port_slot(port_slot), .port_data(port_data));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 32'(exp), 32'(reg_rdata));
  endtask
  task automatic do_commit;
    @(posedge clock);
    commit <= 1'b1;
    @(posedge clock);
    commit <= 1'b0;
    tick(2);
  endtask
  task automatic frame(int exp);
    fwd = 0;
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    tick(36);
    chk("forwarded", 32'(exp), 32'(fwd));
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Port monitor and timeout
  // ****************************************
  always @(negedge clock) begin
    if (nrst && port_valid === 1'b1) begin
      fwd++;
      chk("port_data", 32'hda00_0000 + 32'(port_slot), port_data);
      chk("slot selected", 32'h1, 32'(sel[port_slot]));
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {nrst, reg_wr, reg_rd, commit, go} = '0;
    {reg_addr, reg_wdata, count, lo} = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    tick(2);
    chk("legacy", 32'h1, 32'(legacy));
    rd(8'h68, 8'h00);
    @(posedge clock);
    lo    <= 24'h00_0003;
    count <= 8'h05;
    tick(2);
    chk("sel", 32'h0000_0003, sel);
    wr(8'h68, 8'h81);
    rd(8'h68, 8'h81);
    tick(3);
    chk("sel", 32'h0000_0003, sel);
    do_commit();
    chk("sel", 32'h8100_0003, sel);
    chk("legacy", 32'h0, 32'(legacy));
    frame(4);
    wr(8'h69, 8'hff);
    rd(8'h69, 8'h1f);
    chk("skip", 32'h1f, 32'(skip_used));
    @(posedge clock);
    count <= 8'h00;
    tick(2);
    chk("skip", 32'h0, 32'(skip_used));
    @(posedge clock);
    lo <= 24'h00_0000;
    for (int i = 0; i < 8; i++) begin
      wr(8'h68, 8'h01 << i);
      do_commit();
      chk("sel", 32'h0100_0000 << i, sel);
    end
    wr(8'h68, 8'h00);
    do_commit();
    @(posedge clock);
    count <= 8'h05;
    tick(2);
    chk("sel", 32'h0000_001f, sel);
    chk("skip", 32'h0, 32'(skip_used));
    frame(5);
    @(posedge clock);
    count <= 8'h28;
    tick(2);
    chk("sel", 32'hffff_ffff, sel);
    rd(8'h70, 8'h00);
    @(posedge clock);
    nrst <= 1'b0;
    tick(2);
    chk("sel", 32'h0, sel);
    chk("port_slot", 32'h0, 32'(port_slot));
    chk("port_data", 32'h0, port_data);
    @(posedge clock);
    nrst <= 1'b1;
    tick(2);
    chk("sel", 32'hffff_ffff, sel);
    rd(8'h69, 8'h00);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
